// [src/arb_timer_pkg.sv]
// Constants, field layout and state types of the serial arbiter bit timer.
// Assumes a 40 MHz bus clock and a word-addressed Avalon-MM slave port.
// Summary of operation
// RL1: Count low byte readable, writes ignored.
// RL2: Control write or reset clears counter.
// RL3: Mode 00 holds counter cleared and idle.
// RL4: Select 0 counts every fourth bus clock.
// RL5: Select 0: count between two RX falls.
// RL6: Running flag while counting; done on second fall.
// RL7: Select 1 counts half prescaler rate.
// RL8: Select 1: start on low, even immediately.
// RL9: Select 1: stop on next RX rise.
// RL10: Mode 10 selects arbitration.
// RL11: Arbitration restarts counter on TX rise.
// RL12: Sample RX at 0x38 or 0x08.
// RL13: RX low at sample sets lost flag.
// RL14: Lost flag forces TX pin high.
// RL15: Early TX low resets, waits TX rise.
// RL16: Mode 00 idle, 01 measure, 10 arbitrate.
// RL17: Lost cleared by writing upper mode zero.
// RL18: Nine-bit counter with sticky overflow flag.
// RL19: Counter MSB readable in control register.
// RL20: RX line synchronised before edge detection.
package arb_timer_pkg;
   localparam int          CNT_W          = 9;
   localparam logic [3:0]  CTL_ADDR       = 4'h0;
   localparam logic [3:0]  LOW_ADDR       = 4'h4;
   localparam int          BIT_MODE_UP    = 7;
   localparam int          BIT_MODE_LO    = 6;
   localparam int          BIT_LOST       = 5;
   localparam int          BIT_ACLK       = 4;
   localparam int          BIT_FIN        = 3;
   localparam int          BIT_RUN        = 2;
   localparam int          BIT_OVFL       = 1;
   localparam int          BIT_MSB        = 0;
   localparam logic [1:0]  MODE_IDLE      = 2'h0;
   localparam logic [1:0]  MODE_MEAS      = 2'h1;
   localparam logic [1:0]  MODE_ARB       = 2'h2;
   localparam logic [1:0]  DIV_LAST       = 2'h3;
   localparam logic [8:0]  SAMPLE_PT_BUS  = 9'h038;
   localparam logic [8:0]  SAMPLE_PT_PRE  = 9'h008;
   localparam logic [8:0]  CNT_ZERO       = 9'h000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [23:0] PAD_ZERO       = 24'h000000;

   typedef enum logic [1:0] {
      M_WAIT = 2'b00,
      M_RUN  = 2'b01,
      M_DONE = 2'b10
   } meas_state_t;

   typedef enum logic [0:0] {
      A_IDLE  = 1'b0,
      A_COUNT = 1'b1
   } arb_state_t;
endpackage : arb_timer_pkg

// [src/rx_line_if.sv]
// Carrier for the synchronised receive line and its edges.
// Assumes producer and consumer share one clock.
`timescale 1ns/1ps
interface rx_line_if;
   logic level;
   logic fall;
   logic rise;
   modport src (output level, output fall, output rise);
   modport dst (input level, input fall, input rise);
endinterface : rx_line_if

// [src/rx_line_sync.sv]
// Two-stage synchroniser and edge detector for the receive pin.
// Assumes rx_pin_i is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module rx_line_sync
   import arb_timer_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic rx_pin_i,
   rx_line_if.src    rx
);
   typedef struct packed {
      logic meta;
      logic stable;
      logic prev;
   } sync_t;

   sync_t s_reg;
   sync_t s_next;

   always_comb begin
      s_next        = s_reg;
      s_next.meta   = rx_pin_i;
      s_next.stable = s_reg.meta;     // [RL20]
      s_next.prev   = s_reg.stable;
   end

   // Idle line is high
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rx.level = s_reg.stable;
   assign rx.fall  = s_reg.prev & ~s_reg.stable;
   assign rx.rise  = ~s_reg.prev & s_reg.stable;
endmodule : rx_line_sync

// [src/serial_arbiter_bit_timer.sv]
// Arbiter counter beside the serial port: bit time and break measurement, bus arbitration.
// Assumes presc_tick_i is a one-cycle prescaler pulse and internal_transmit_out_i is
// driven on sys_clk_i by the serial port; rx_pin_i is asynchronous.
`timescale 1ns/1ps
module serial_arbiter_bit_timer
   import arb_timer_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic      [1:0]  avs_response_o,
   output logic             avs_waitrequest_o,
   input  wire logic        rx_pin_i,
   input  wire logic        internal_transmit_out_i,
   input  wire logic        presc_tick_i,
   output logic             tx_pin_o
);
   typedef struct packed {
      logic [1:0]       mode;
      logic             aclk;
      logic             lost;
      logic             fin;
      logic             run;
      logic             ovfl;
      logic [CNT_W-1:0] cnt;
      logic [1:0]       div;
      logic             half;
      meas_state_t      mst;
      arb_state_t       ast;
      logic             tx_prev;
      logic             ack;
      logic [31:0]      rdata;
      logic [1:0]       resp;
   } state_t;

   state_t s_reg;
   state_t s_next;

   rx_line_if rx ();

   rx_line_sync u_rx_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .rx_pin_i  (rx_pin_i),
      .rx        (rx.src)
   );

   // Counter step with wrap carry
   function automatic logic [CNT_W:0] cnt_step(input logic [CNT_W-1:0] c);
      cnt_step = {1'b0, c} + {{CNT_W{1'b0}}, 1'b1};
   endfunction : cnt_step

   function automatic logic [7:0] ctl_byte(input state_t s);
      ctl_byte              = 8'h00;
      ctl_byte[BIT_MODE_UP] = s.mode[1];
      ctl_byte[BIT_MODE_LO] = s.mode[0];
      ctl_byte[BIT_LOST]    = s.lost;
      ctl_byte[BIT_ACLK]    = s.aclk;
      ctl_byte[BIT_FIN]     = s.fin;
      ctl_byte[BIT_RUN]     = s.run;
      ctl_byte[BIT_OVFL]    = s.ovfl;
      ctl_byte[BIT_MSB]     = s.cnt[CNT_W-1];
   endfunction : ctl_byte

   logic             div_tick;
   logic             half_tick;
   logic             tick;
   logic             req;
   logic             accept;
   logic             ctl_wr;
   logic             tx_rise;
   logic             fin_set;
   logic             lost_set;
   logic             ovfl_set;
   logic [CNT_W:0]   stepped;
   logic [CNT_W-1:0] sample_pt;

   always_comb begin
      s_next    = s_reg;
      fin_set   = 1'b0;
      lost_set  = 1'b0;
      ovfl_set  = 1'b0;
      stepped   = cnt_step(s_reg.cnt);
      div_tick  = (s_reg.div == DIV_LAST);
      half_tick = presc_tick_i & s_reg.half;
      tick      = s_reg.aclk ? half_tick : div_tick;       // [RL4] [RL7]
      sample_pt = s_reg.aclk ? SAMPLE_PT_PRE : SAMPLE_PT_BUS;
      tx_rise   = internal_transmit_out_i & ~s_reg.tx_prev;
      req       = avs_read_i | avs_write_i;
      accept    = req & s_reg.ack;
      ctl_wr    = avs_write_i & accept & (avs_address_i == CTL_ADDR) & avs_byteenable_i[0];

      s_next.div     = s_reg.div + 2'h1;
      s_next.tx_prev = internal_transmit_out_i;
      if (presc_tick_i) begin
         s_next.half = ~s_reg.half;
      end

      case (s_reg.mode)                                     // [RL16]
         MODE_MEAS: begin
            case (s_reg.mst)
               M_WAIT: begin
                  if (s_reg.aclk ? ~rx.level : rx.fall) begin    // [RL5] [RL8]
                     s_next.mst = M_RUN;
                  end
               end
               M_RUN: begin
                  if (tick) begin
                     s_next.cnt = stepped[CNT_W-1:0];
                     ovfl_set   = stepped[CNT_W];                // [RL18]
                  end
                  if (s_reg.aclk ? rx.rise : rx.fall) begin      // [RL5] [RL9]
                     s_next.mst = M_DONE;
                     fin_set    = ~s_reg.aclk | 1'b1;            // [RL6]
                  end
               end
               M_DONE: begin
                  s_next.mst = M_DONE;
               end
               default: begin
                  s_next.mst = M_WAIT;
               end
            endcase
         end
         MODE_ARB: begin                                    // [RL10]
            case (s_reg.ast)
               A_IDLE: begin
                  if (tx_rise) begin                         // [RL11]
                     s_next.cnt = CNT_ZERO;
                     s_next.ast = A_COUNT;
                  end
               end
               A_COUNT: begin
                  if (s_reg.cnt == sample_pt) begin          // [RL12]
                     lost_set   = ~rx.level;                 // [RL13]
                     s_next.ast = A_IDLE;
                  end else if (~internal_transmit_out_i) begin
                     s_next.cnt = CNT_ZERO;                  // [RL15]
                     s_next.ast = A_IDLE;
                  end else if (tick) begin
                     s_next.cnt = stepped[CNT_W-1:0];
                     ovfl_set   = stepped[CNT_W];            // [RL18]
                  end
               end
               default: begin
                  s_next.ast = A_IDLE;
               end
            endcase
         end
         default: begin
            // Idle and the unused code keep the counter cleared
            s_next.cnt = CNT_ZERO;                           // [RL3]
            s_next.mst = M_WAIT;
            s_next.ast = A_IDLE;
         end
      endcase

      if (ctl_wr) begin
         s_next.mode = avs_writedata_i[BIT_MODE_UP:BIT_MODE_LO];
         s_next.aclk = avs_writedata_i[BIT_ACLK];
         s_next.cnt  = CNT_ZERO;                            // [RL2] [RL19]
         s_next.fin  = 1'b0;
         s_next.ovfl = 1'b0;
         s_next.mst  = M_WAIT;
         s_next.ast  = A_IDLE;
         if (~avs_writedata_i[BIT_MODE_UP]) begin
            s_next.lost = 1'b0;                             // [RL17]
         end
      end
      // Hardware set wins over a clear in the same cycle
      s_next.fin  = s_next.fin | fin_set;
      s_next.ovfl = s_next.ovfl | ovfl_set;
      s_next.lost = s_next.lost | lost_set;
      s_next.run  = ((s_next.mode == MODE_MEAS) & (s_next.mst == M_RUN)) |
                    ((s_next.mode == MODE_ARB) & (s_next.ast == A_COUNT));    // [RL6]

      // One wait state: data is latched on the first edge, accepted on the second
      s_next.ack = req & ~s_reg.ack;
      if (req & ~s_reg.ack) begin
         s_next.rdata = 32'h00000000;
         s_next.resp  = RESP_OKAY;
         case (avs_address_i)
            CTL_ADDR: begin
               if (avs_read_i) begin
                  s_next.rdata = {PAD_ZERO, ctl_byte(s_reg)};
               end
            end
            LOW_ADDR: begin
               if (avs_read_i) begin
                  s_next.rdata = {PAD_ZERO, s_reg.cnt[7:0]};   // [RL1]
               end
            end
            default: begin
               s_next.resp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg         <= '0;
         s_reg.tx_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_waitrequest_o = req & ~s_reg.ack;
   assign avs_readdata_o    = s_reg.rdata;
   assign avs_response_o    = s_reg.resp;
   assign tx_pin_o          = internal_transmit_out_i | s_reg.lost;   // [RL14]

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic low_rd_acc;
   assign low_rd_acc = avs_read_i & ~avs_waitrequest_o & (avs_address_i == LOW_ADDR);

   sequence meas_wait_bus;
      (s_reg.mode == MODE_MEAS) && !s_reg.aclk && (s_reg.mst == M_WAIT);
   endsequence
   sequence meas_run_bus;
      (s_reg.mode == MODE_MEAS) && !s_reg.aclk && (s_reg.mst == M_RUN);
   endsequence

   chk_low_read_value: assert property (low_rd_acc |-> avs_readdata_o[7:0] == $past(s_reg.cnt[7:0]))  // [RL1]
      else $error("count low read does not match counter");
   chk_ctl_write_clear: assert property (ctl_wr |=> s_reg.cnt == CNT_ZERO)  // [RL2] [RL19]
      else $error("control write did not clear counter");
   chk_idle_held: assert property ((s_reg.mode == MODE_IDLE) |-> s_reg.cnt == CNT_ZERO && !s_reg.run)  // [RL3]
      else $error("idle mode counter not cleared");
   chk_div_step: assert property (((s_reg.mode == MODE_MEAS) && !s_reg.aclk && !$past(ctl_wr)
         && s_reg.cnt != $past(s_reg.cnt)) |-> $past(div_tick))  // [RL4]
      else $error("counter stepped without quarter rate tick");
   chk_fall_start: assert property ((meas_wait_bus ##0 rx.fall && !ctl_wr) |=> meas_run_bus)  // [RL5]
      else $error("falling edge did not start measurement");
   chk_second_fall: assert property ((meas_run_bus ##0 rx.fall && !ctl_wr) |=> s_reg.fin && !s_reg.run)  // [RL6]
      else $error("second falling edge did not finish measurement");
   chk_break_start: assert property (((s_reg.mode == MODE_MEAS) && s_reg.aclk && (s_reg.mst == M_WAIT)
         && !rx.level && !ctl_wr) |=> s_reg.run)  // [RL8]
      else $error("low line did not start break count");
   chk_break_stop: assert property (((s_reg.mode == MODE_MEAS) && s_reg.aclk && (s_reg.mst == M_RUN)
         && rx.rise && !ctl_wr) |=> s_reg.fin ##1 $stable(s_reg.cnt) [*3])  // [RL9]
      else $error("rising edge did not stop break count");
   chk_lost_set: assert property (((s_reg.mode == MODE_ARB) && (s_reg.ast == A_COUNT)
         && (s_reg.cnt == sample_pt) && !rx.level) |=> s_reg.lost)  // [RL12] [RL13]
      else $error("low sample did not set lost flag");
   chk_tx_forced: assert property (s_reg.lost |-> tx_pin_o)  // [RL14]
      else $error("transmit pin not forced while lost");
endmodule : serial_arbiter_bit_timer

// [sim/bus_node_model.sv]
// Other node sharing the open-drain serial bus with the timer's transmit pin.
// Assumes a pull-up: the bus is low only while some node drives it low.
`timescale 1ns/1ps
module bus_node_model (
   input  wire logic sys_clk_i,
   input  wire logic tx_line_i,
   input  wire logic dominant_i,
   output logic      bus_level_o
);
   logic drive_low_reg = 1'b0;

   always_ff @(posedge sys_clk_i) begin
      drive_low_reg <= dominant_i;
   end

   // Wired-AND of both drivers, released bus is pulled high
   assign bus_level_o = tx_line_i & ~drive_low_reg;
endmodule : bus_node_model

// [sim/serial_arbiter_bit_timer_bench.sv]
// Self-checking bench of the serial arbiter bit timer over its Avalon-MM port.
// Assumes the design files and the bus node model are compiled first.
`timescale 1ns/1ps
module serial_arbiter_bit_timer_bench;
   import arb_timer_pkg::*;
   logic        sys_clk, rst, rd, wr, itx, tick, dom, wreq, rx, txp;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, q, c;
   logic [1:0]  resp, qresp, tick_cnt;
   int          fails, total_checks;

   serial_arbiter_bit_timer dut (.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_response_o(resp), .avs_waitrequest_o(wreq),
      .rx_pin_i(rx), .internal_transmit_out_i(itx), .presc_tick_i(tick), .tx_pin_o(txp));
   bus_node_model node (.sys_clk_i(sys_clk), .tx_line_i(txp), .dominant_i(dom), .bus_level_o(rx));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Prescaler pulse every fourth clock
   always @(posedge sys_clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      tick     <= (tick_cnt == 2'h3);
   end

   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One bus transfer; read data and response land in q and qresp
   // Request held until the rising edge that samples waitrequest low; data taken there
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      rd    <= ~w;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      do begin
         @(posedge sys_clk);
         n++;
         if (n > 50) begin
            fails++;
            tally_and_finish();
         end
      end while (wreq !== 1'b0);
      q     = rdata;
      qresp = resp;
      rd    <= 1'b0;
      wr    <= 1'b0;
   endtask : xfer

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   task automatic low_pulse();
      @(posedge sys_clk); dom <= 1'b1;
      @(posedge sys_clk); dom <= 1'b0;
   endtask : low_pulse

   // Select 0 measurement between two falls d clocks apart
   task automatic meas0(input int d, input logic ovf);
      xfer(1'b1, CTL_ADDR, 32'h0000_0040);
      cyc(10);
      fork
         begin low_pulse(); cyc(d - 2); low_pulse(); end
         begin cyc(30); xfer(1'b0, CTL_ADDR, 32'h0); check({31'h0, q[BIT_RUN]}, 32'h1); end
      join
      cyc(10);
      xfer(1'b0, CTL_ADDR, 32'h0);
      c = q;
      check({26'h0, q[7:2]}, 32'h12);
      check({31'h0, q[BIT_OVFL]}, {31'h0, ovf});
      xfer(1'b0, LOW_ADDR, 32'h0);
      c = {23'h0, c[BIT_MSB], q[7:0]} + (ovf ? 32'h200 : 32'h0);
      check({31'h0, (c >= d / 4 - 1) && (c <= d / 4 + 1)}, 32'h1);
   endtask : meas0

   // Arbitration round; hit makes the other node dominant over the sample point
   task automatic arb(input logic sel, input logic hit);
      int sp;
      sp = sel ? 64 : 224;
      xfer(1'b1, CTL_ADDR, sel ? 32'h90 : 32'h80);
      @(posedge sys_clk); itx <= 1'b0;
      cyc(4);
      @(posedge sys_clk); itx <= 1'b1;
      cyc(sp / 2);
      dom <= hit;
      cyc(sp);
      dom <= 1'b0;
      cyc(10);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check({31'h0, q[BIT_LOST]}, {31'h0, hit});
      if (!hit) begin
         xfer(1'b0, LOW_ADDR, 32'h0);
         check(q, sel ? 32'h08 : 32'h38);
      end
      @(posedge sys_clk); itx <= 1'b0;
      cyc(2);
      check({31'h0, txp}, {31'h0, hit});
      xfer(1'b1, CTL_ADDR, 32'h0);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check(q, 32'h0);
      check({31'h0, txp}, 32'h0);
      @(posedge sys_clk); itx <= 1'b1;
   endtask : arb

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0;
      itx = 1'b1; dom = 1'b0; tick = 1'b0; tick_cnt = 2'h0;
      fails = 0; total_checks = 0;
      cyc(12);
      rst <= 1'b0;
      xfer(1'b0, CTL_ADDR, 32'h0);
      check(q, 32'h0);
      xfer(1'b0, 4'h8, 32'h0);
      check({qresp, q[29:0]}, 32'h8000_0000);
      meas0(1100, 1'b0);
      xfer(1'b0, LOW_ADDR, 32'h0);
      c = q;
      xfer(1'b1, LOW_ADDR, 32'h0000_00A5);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check(q, c);
      meas0(2400, 1'b1);
      xfer(1'b1, CTL_ADDR, 32'h0000_0040);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check(q, 32'h40);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check(q, 32'h0);
      xfer(1'b1, CTL_ADDR, 32'h0);
      low_pulse(); cyc(100); low_pulse(); cyc(100);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check(q, 32'h0);
      // Break length: bus already low when select 1 measurement starts
      dom <= 1'b1;
      cyc(10);
      xfer(1'b1, CTL_ADDR, 32'h0000_0050);
      cyc(160);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check({31'h0, q[BIT_RUN]}, 32'h1);
      dom <= 1'b0;
      cyc(40);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check({26'h0, q[7:2]}, 32'h16);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check({31'h0, (q >= 32'd19) && (q <= 32'd23)}, 32'h1);
      arb(1'b0, 1'b0);
      arb(1'b1, 1'b0);
      arb(1'b0, 1'b1);
      arb(1'b1, 1'b1);
      // Own transmit low before the sample point resets the arbitration counter and waits for the next transmit rise
      xfer(1'b1, CTL_ADDR, 32'h0000_0080);
      @(posedge sys_clk); itx <= 1'b0;
      cyc(4);
      @(posedge sys_clk); itx <= 1'b1;
      cyc(20);
      itx <= 1'b0;
      cyc(300);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check(q, 32'h0);
      xfer(1'b0, CTL_ADDR, 32'h0);
      check(q, 32'h80);
      // Next transmit rise resumes arbitration up to the sample point
      itx <= 1'b1;
      cyc(240);
      xfer(1'b0, LOW_ADDR, 32'h0);
      check(q, {23'h0, SAMPLE_PT_BUS});
      tally_and_finish();
   end
endmodule : serial_arbiter_bit_timer_bench
